// *** logic/oppc_top.sv ***
// What this block does
// [R1] Two 3-bit pad strength codes for Port B
// [R2] Host writes zero to reserved bits
// [R3] Bit 0 enables Port A, else high-Z
// [R4] Bit 1 enables Port B, else high-Z
// [R5] Bit 2 enables pixel clock, else high-Z
// [R6] Bit 3 enables sync and clock outputs
// [R7] Bit 4 puts half clock on TDO
// [R8] Latched enable delayed one line clock unless bypassed
// [R9] Bit 6 latches enable pin on line clock
// [R10] Bit 7 ignores the enable pin
// [R11] Power code: active, or tri-state and divide
// [R12] Host slows bus below 100 kbit/s at divide-by-8
// [R13] Select bit: half clock or data bit to TDO
// [R14] Bit 4 is polarity or TDO data
// [R15] Slicer switch-off powers down and resets slicer
// [R16] Status register reads eight Port B lines
// [R17] Controls reset to zero, enables by parameter
`timescale 1ns/1ps
`default_nettype none
module oppc_top
  import oppc_pkg::*;
#(
  parameter logic [6:0]       DEV_ADDR  = 7'h43, // Serial bus device address
  parameter logic [OE_EN_W-1:0] OE_EN_RST = 4'h0   // Reset of the four port enables
) (
  input  wire logic       core_clk,           // 10 MHz core clock
  input  wire logic       rst_n,              // Async reset, active low
  input  wire logic       ce,                 // Clock enable, freezes state when low
  input  wire logic       scl_in,             // Serial bus clock pin
  input  wire logic       sda_in,             // Serial bus data pin level
  output logic            sda_out,            // Serial bus data drive value
  output logic            sda_oe_n,           // Low while pulling data low
  input  wire logic       llc_in,             // Line locked clock pin
  input  wire logic       oe_pin_n,           // External output enable pin, active low
  input  wire logic       jtag_tlr,           // JTAG rests in Test-Logic-Reset
  input  wire logic [7:0] port_b_lines,       // Port B line levels
  output logic            port_a_oe_n,        // Port A enable, low drives
  output logic            port_b_oe_n,        // Port B enable, low drives
  output logic            pixclk_oe_n,        // Pixel clock enable, low drives
  output logic            sync_oe_n,          // Reference, field and clock pads
  output logic            tdo_out,            // Test data output value
  output logic            tdo_oe_n,           // Test data output enable, low drives
  output logic            half_rate_line_clock, // Line clock divided by two
  output logic [2:0]      port_b_data_strength, // Port B data pad strength
  output logic [2:0]      sync_pad_strength,  // Sync pad strength
  output logic            clk_div_stb,        // Internal clock enable pulse
  output logic            slicer_power_down,  // Slicer off, its registers held reset
  output logic            bus_reset_req,      // Serial bus reset control bit
  output logic            old_llc_timing      // Long hold line clock timing
);

  logic [7:0]  output_enable_control;
  logic [7:0]  power_and_line_clock_control;
  logic [7:0]  port_b_pad_strength;
  logic [7:0]  port_b_pin_state;
  logic [1:0]  scl_m, sda_m, llc_m, oe_m;
  logic [7:0]  pb_m;
  logic        scl_s, sda_s, llc_s, oe_s, scl_d, sda_d, llc_d;
  logic        scl_rise, scl_fall, start_c, stop_c, llc_rise;
  oppc_state_t st;
  logic [2:0]  bit_cnt;
  logic [7:0]  shreg, tx, sub;
  logic        is_read, nack, wr_en, rise_seen;
  logic [7:0]  wr_data;
  logic        oe_lat, oe_lat_d, oe_used, ext_en, active;
  logic [2:0]  div_cnt, div_mask;
  logic [1:0]  lowpow;
  logic        test_out_select, half_clock_polarity, half_clock_test_out_en;

  // Readback mux, used by both read entry points
  function automatic logic [7:0] oppc_rd(input logic [7:0] a, input logic [7:0] oe,
                                         input logic [7:0] pl, input logic [7:0] str,
                                         input logic [7:0] pb);
    logic [7:0] r;
    r = BYTE_ZERO;
    unique case (a)
      ADDR_OE_CTRL:  r = oe;
      ADDR_PWR_LLC:  r = pl;
      ADDR_PB_STR:   r = str;
      ADDR_PB_STATE: r = pb;
      default:       r = BYTE_ZERO;
    endcase
    return r;
  endfunction : oppc_rd

  // Two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 2'h3;
      sda_m <= 2'h3;
      llc_m <= 2'h0;
      oe_m  <= 2'h3;
      pb_m  <= BYTE_ZERO;
      port_b_pin_state <= BYTE_ZERO;
    end else if (ce) begin
      scl_m <= {scl_m[0], scl_in};
      sda_m <= {sda_m[0], sda_in};
      llc_m <= {llc_m[0], llc_in};
      oe_m  <= {oe_m[0], oe_pin_n};
      pb_m  <= port_b_lines;
      port_b_pin_state <= pb_m; // [R16]
    end
  end
  assign scl_s = scl_m[1];
  assign sda_s = sda_m[1];
  assign llc_s = llc_m[1];
  assign oe_s  = oe_m[1];

  // Edge history of synchronised levels
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      llc_d <= 1'b0;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      llc_d <= llc_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  assign llc_rise = llc_s & ~llc_d;

  // Serial bus slave: address, sub-address, then data with auto-increment
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg   <= BYTE_ZERO;
      tx      <= BYTE_ZERO;
      sub     <= BYTE_ZERO;
      is_read <= 1'b0;
      nack    <= 1'b0;
      wr_en   <= 1'b0;
      wr_data <= BYTE_ZERO;
      rise_seen <= 1'b0;
    end else if (ce) begin
      wr_en <= 1'b0;
      if (start_c) begin
        st        <= ST_ADDR;
        bit_cnt   <= 3'h0;
        rise_seen <= 1'b0;
      end else if (stop_c) begin
        st <= ST_IDLE;
      end else if (scl_rise) begin
        rise_seen <= 1'b1;
        if (st == ST_RACK) begin
          nack <= sda_s;
        end else begin
          shreg <= {shreg[6:0], sda_s};
        end
      end else if (scl_fall) begin
        rise_seen <= 1'b0;
        unique case (st)
          ST_IDLE: ;
          ST_ADDR: begin
            // The fall that closes a start carries no bit, so it is skipped
            if (rise_seen) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == BIT_LAST) begin
                is_read <= shreg[0];
                st <= (shreg[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt <= 3'h0;
            if (is_read) begin
              tx <= oppc_rd(sub, output_enable_control, power_and_line_clock_control,
                            port_b_pad_strength, port_b_pin_state); // [R16]
              st <= ST_RDATA;
            end else begin
              st <= ST_SUB;
            end
          end
          ST_SUB, ST_WDATA: begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST) begin
              if (st == ST_SUB) begin
                sub <= shreg;
                st  <= ST_SUB_ACK;
              end else begin
                wr_en   <= 1'b1;
                wr_data <= shreg;
                st      <= ST_WACK;
              end
            end
          end
          ST_SUB_ACK: begin
            bit_cnt <= 3'h0;
            st      <= ST_WDATA;
          end
          ST_WACK: begin
            bit_cnt <= 3'h0;
            sub     <= sub + 8'h01;
            st      <= ST_WDATA;
          end
          ST_RDATA: begin
            bit_cnt <= bit_cnt + 3'h1;
            tx      <= {tx[6:0], 1'b0};
            if (bit_cnt == BIT_LAST) begin
              st <= ST_RACK;
            end
          end
          ST_RACK: begin
            bit_cnt <= 3'h0;
            if (nack) begin
              st <= ST_IDLE;
            end else begin
              tx <= oppc_rd(sub + 8'h01, output_enable_control,
                            power_and_line_clock_control, port_b_pad_strength,
                            port_b_pin_state);
              sub <= sub + 8'h01;
              st  <= ST_RDATA;
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low, release otherwise
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((st == ST_ADDR_ACK) | (st == ST_SUB_ACK) | (st == ST_WACK) |
                      ((st == ST_RDATA) & ~tx[7]));

  // Control registers; read-only status ignores writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_enable_control        <= {4'h0, OE_EN_RST}; // [R17]
      power_and_line_clock_control <= BYTE_ZERO; // [R17]
      port_b_pad_strength          <= BYTE_ZERO; // [R17]
    end else if (ce && wr_en) begin
      unique case (sub)
        ADDR_OE_CTRL: output_enable_control <= wr_data;
        ADDR_PWR_LLC: power_and_line_clock_control <= wr_data; // [R2]
        ADDR_PB_STR:  port_b_pad_strength <= wr_data;
        default: ;
      endcase
    end
  end
  assign port_b_data_strength = port_b_pad_strength[STR_DATA_MSB:STR_DATA_LSB]; // [R1]
  assign sync_pad_strength    = port_b_pad_strength[STR_SYNC_MSB:STR_SYNC_LSB]; // [R1]
  assign lowpow               = power_and_line_clock_control[PL_LP_MSB:PL_LP_LSB];
  assign test_out_select      = power_and_line_clock_control[PL_TSEL];
  assign half_clock_polarity  = power_and_line_clock_control[PL_POL];
  assign half_clock_test_out_en = output_enable_control[OE_TDO_HALF];
  assign slicer_power_down    = power_and_line_clock_control[PL_SLC_OFF]; // [R15]
  assign bus_reset_req        = power_and_line_clock_control[PL_BUS_RST];
  assign old_llc_timing       = power_and_line_clock_control[PL_OLD_LLC];

  // Half-rate clock and enable-pin latch on line clock edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_rate_line_clock <= 1'b0;
      oe_lat   <= 1'b1;
      oe_lat_d <= 1'b1;
    end else if (ce && llc_rise) begin
      half_rate_line_clock <= ~half_rate_line_clock;
      oe_lat   <= oe_s; // [R9]
      oe_lat_d <= oe_lat; // [R8]
    end
  end

  // Pin qualification: direct, latched, latched and delayed, or ignored
  assign oe_used = !output_enable_control[OE_LATCH] ? oe_s :
                   (output_enable_control[OE_NO_DELAY] ? oe_lat : oe_lat_d); // [R8] [R9]
  assign ext_en  = output_enable_control[OE_PIN_OFF] | ~oe_used; // [R10]
  assign active  = (lowpow == LP_ACTIVE) & ext_en; // [R11]

  // Pad enables, low while driven
  assign port_a_oe_n = ~(output_enable_control[OE_PORT_A] & active); // [R3]
  assign port_b_oe_n = ~(output_enable_control[OE_PORT_B] & active); // [R4]
  assign pixclk_oe_n = ~(output_enable_control[OE_PIXCLK] & active); // [R5]
  assign sync_oe_n   = ~(output_enable_control[OE_SYNC] & active); // [R6]

  // Test output: only while the JTAG port is idle in reset state
  assign tdo_out  = test_out_select ? (half_rate_line_clock ^ half_clock_polarity)
                                    : half_clock_polarity; // [R13] [R14]
  assign tdo_oe_n = ~(jtag_tlr & (~test_out_select | half_clock_test_out_en)); // [R7]

  // Power mode clock divider; free runs so a mode change settles quickly
  always_comb begin
    unique case (lowpow)
      LP_ACTIVE: div_mask = 3'h0;
      LP_DIV2:   div_mask = DIV_MASK2;
      LP_DIV4:   div_mask = DIV_MASK4;
      LP_DIV8:   div_mask = DIV_MASK8;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt     <= 3'h0;
      clk_div_stb <= 1'b0;
    end else if (ce) begin
      div_cnt     <= div_cnt + 3'h1;
      clk_div_stb <= (div_cnt & div_mask) == 3'h0; // [R11]
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);

  AST_LOWPOW_TRI: assert property ((lowpow != LP_ACTIVE) |->  // [R11]
    port_a_oe_n && port_b_oe_n && pixclk_oe_n && sync_oe_n)
    else $error("outputs driven in low power mode");
  AST_DIV8: assert property ((clk_div_stb && lowpow == LP_DIV8 && $past(lowpow) == LP_DIV8) // [R11]
    |=>
    (!clk_div_stb || lowpow != LP_DIV8)[*7])
    else $error("divide by 8 strobe too early");
  AST_PORT_B_OFF: assert property ((!output_enable_control[OE_PORT_B]) |->  // [R4]
    port_b_oe_n)
    else $error("port B driven while disabled");
  AST_PIN_IGNORED: assert property ((output_enable_control[OE_PIN_OFF] &&  // [R10]
    lowpow == LP_ACTIVE && output_enable_control[OE_SYNC]) |-> !sync_oe_n)
    else $error("enable pin not ignored");
  AST_LATCH: assert property (llc_rise |=> oe_lat == $past(oe_s)) // [R9]
    else $error("enable pin not latched on line clock");
  AST_DELAY: assert property (llc_rise ##1 (output_enable_control[OE_LATCH] &&  // [R8]
    !output_enable_control[OE_NO_DELAY]) |-> oe_used == $past(oe_lat))
    else $error("enable pin delay wrong");
  AST_HALF: assert property (llc_rise |=>  // [R7]
    half_rate_line_clock != $past(half_rate_line_clock))
    else $error("half rate clock did not toggle");
  AST_TDO_BIT: assert property ((jtag_tlr && !test_out_select) |->  // [R14]
    !tdo_oe_n && tdo_out == half_clock_polarity)
    else $error("TDO does not carry data bit");
  AST_STRENGTH: assert property ((wr_en && sub == ADDR_PB_STR) |=>  // [R1]
    port_b_data_strength == $past(wr_data[STR_DATA_MSB:STR_DATA_LSB]))
    else $error("pad strength write lost");
  AST_SLICER: assert property ((wr_en && sub == ADDR_PWR_LLC) |=>  // [R15]
    slicer_power_down == $past(wr_data[PL_SLC_OFF]))
    else $error("slicer switch-off not applied");
  AST_PORT_A_ON: assert property ((output_enable_control[OE_PORT_A] && active) |->  // [R3]
    !port_a_oe_n)
    else $error("port A not driven while enabled");
  AST_PIXCLK_OFF: assert property ((!output_enable_control[OE_PIXCLK]) |->  // [R5]
    pixclk_oe_n)
    else $error("pixel clock driven while disabled");
  AST_TDO_CLK: assert property ((jtag_tlr && test_out_select && half_clock_test_out_en)  // [R13]
    |-> !tdo_oe_n && tdo_out == (half_rate_line_clock ^ half_clock_polarity))
    else $error("TDO does not carry half rate clock");

endmodule : oppc_top
`default_nettype wire

// *** logic/oppc_pkg.sv ***
`default_nettype none
package oppc_pkg;
  // Register sub-addresses on the serial control bus
  localparam logic [7:0] ADDR_PWR_LLC   = 8'haa;
  localparam logic [7:0] ADDR_PB_STATE  = 8'hab;
  localparam logic [7:0] ADDR_OE_CTRL   = 8'hf2;
  localparam logic [7:0] ADDR_PB_STR    = 8'hf9;
  // Output enable control fields
  localparam int OE_PORT_A   = 0;
  localparam int OE_PORT_B   = 1;
  localparam int OE_PIXCLK   = 2;
  localparam int OE_SYNC     = 3;
  localparam int OE_TDO_HALF = 4;
  localparam int OE_NO_DELAY = 5;
  localparam int OE_LATCH    = 6;
  localparam int OE_PIN_OFF  = 7;
  localparam int OE_EN_W     = 4;
  // Power and line clock control fields
  localparam int PL_LP_LSB  = 0;
  localparam int PL_LP_MSB  = 1;
  localparam int PL_BUS_RST = 2;
  localparam int PL_TSEL    = 3;
  localparam int PL_POL     = 4;
  localparam int PL_SLC_OFF = 5;
  localparam int PL_OLD_LLC = 6;
  // Pad strength fields
  localparam int STR_DATA_LSB = 0;
  localparam int STR_DATA_MSB = 2;
  localparam int STR_SYNC_LSB = 3;
  localparam int STR_SYNC_MSB = 5;
  // Low power codes
  localparam logic [1:0] LP_ACTIVE = 2'h0;
  localparam logic [1:0] LP_DIV2   = 2'h1;
  localparam logic [1:0] LP_DIV4   = 2'h2;
  localparam logic [1:0] LP_DIV8   = 2'h3;
  localparam logic [2:0] DIV_MASK2 = 3'h1;
  localparam logic [2:0] DIV_MASK4 = 3'h3;
  localparam logic [2:0] DIV_MASK8 = 3'h7;
  // Serial bus framing
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } oppc_state_t;
endpackage : oppc_pkg
`default_nettype wire

// *** dv/oppc_i2c_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Serial control host, open drain data, paced off the core clock
module oppc_i2c_host #(
  parameter logic [6:0] DEV = 7'h43 // Device address to call
) (
  input  wire logic clk,      // Core clock for pacing
  input  wire logic sda,      // Resolved data wire
  output logic      scl,      // Bus clock, high when idle
  output logic      sda_pull  // High pulls data low
);
  // 101 cycles a bit keeps under 100 kbit/s even at divide-by-8
  localparam int PH = 45;
  localparam int HD = 28;
  int nacks;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
  end
  // Every edge lands a fixed skew after a core clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // Data moves only mid low phase so it never reads as start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    tick(HD);
    scl = 1'b1;
    tick(PH);
    r = sda;
    scl = 1'b0;
    tick(HD);
  endtask : bit_io
  task automatic start;
    sda_pull = 1'b0;
    tick(HD);
    scl = 1'b1;
    tick(HD);
    sda_pull = 1'b1;
    tick(HD);
    scl = 1'b0;
    tick(HD);
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    tick(HD);
    scl = 1'b1;
    tick(HD);
    sda_pull = 1'b0;
    tick(HD);
  endtask : stop
  task automatic put(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], a);
    bit_io(1'b1, a);
    if (a) nacks++;
  endtask : put
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    start();
    put({DEV, 1'b0});
    put(sub);
    put(d);
    stop();
  endtask : wr
  // Single byte read, closed with a not-acknowledge
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    start();
    put({DEV, 1'b0});
    put(sub);
    start();
    put({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    stop();
  endtask : rd
endmodule : oppc_i2c_host
`default_nettype wire

// *** dv/oppc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module oppc_top_test;
  import oppc_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n, line_clk, oe_pin_n, jtag_tlr, scl, sda_pull, sda, sda_out, sda_oe_n;
  logic       a_n, b_n, pix_n, sync_n, tdo, tdo_n, half, stb, slc, bus_rst, old_t, ce;
  logic [2:0] str_d, str_s;
  logic [7:0] pb_lines, v, obs, oe_all, exp_q[$];
  string      obs_name;
  event       obs_ev;
  int         err_total, n_tests, cyc, k;
  always #50 core_clk = ~core_clk;
  // Open drain wire with pull-up
  assign sda = ~(sda_pull | ~sda_oe_n);
  // All four pad enables as one byte
  assign oe_all = {4'h0, sync_n, pix_n, b_n, a_n};
  oppc_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .llc_in(line_clk), .oe_pin_n(oe_pin_n),
    .jtag_tlr(jtag_tlr), .port_b_lines(pb_lines), .port_a_oe_n(a_n), .port_b_oe_n(b_n),
    .pixclk_oe_n(pix_n), .sync_oe_n(sync_n), .tdo_out(tdo), .tdo_oe_n(tdo_n),
    .half_rate_line_clock(half), .port_b_data_strength(str_d), .sync_pad_strength(str_s),
    .clk_div_stb(stb), .slicer_power_down(slc), .bus_reset_req(bus_rst), .old_llc_timing(old_t));
  oppc_i2c_host host_u (.clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Driver files the expectation, then shows the result to the watcher
  task automatic note(input string nm, input logic [7:0] exp, input logic [7:0] got);
    exp_q.push_back(exp);
    obs = got;
    obs_name = nm;
    ->obs_ev;
    #1;
  endtask : note
  initial forever begin
    @(obs_ev);
    check(obs_name, obs, exp_q.pop_front());
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : wc
  // Line clock runs only while a test needs it, slow enough to sample
  task automatic pulse;
    wc(5);
    line_clk = 1'b1;
    wc(5);
    line_clk = 1'b0;
    wc(5);
  endtask : pulse
  // Hang guard sized well past the expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    line_clk = 1'b0;
    oe_pin_n = 1'b1;
    jtag_tlr = 1'b1;
    pb_lines = 8'h00;
    v = 8'($urandom(61466));
    repeat (6) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    wc(3);
    note("oe_vec", 8'h0f, {4'h0, sync_n, pix_n, b_n, a_n});
    note("str", 8'h00, {2'h0, str_s, str_d});
    host_u.rd(ADDR_OE_CTRL, v);
    note("oe_ctrl", 8'h00, v);
    host_u.rd(8'h10, v);
    note("unmapped", 8'h00, v);
    $display("reset test done");
    v = 8'($urandom) & 8'h3f; // Reserved bits kept zero
    host_u.wr(ADDR_PB_STR, v);
    wc(2);
    note("data_str", {5'h0, v[2:0]}, {5'h0, str_d});
    note("sync_str", {5'h0, v[5:3]}, {5'h0, str_s});
    host_u.rd(ADDR_PB_STR, obs);
    note("str_rd", v, obs);
    $display("strength test done");
    // One enable at a time with the pin held off but ignored
    for (int i = 0; i < 4; i++) begin
      host_u.wr(ADDR_OE_CTRL, 8'h80 | (8'h01 << i));
      wc(4);
      note("oe_vec", 8'h0f & ~(8'h01 << i), oe_all);
    end
    host_u.wr(ADDR_OE_CTRL, 8'h0f);
    wc(4);
    note("oe_pin_off", 8'h0f, {4'h0, sync_n, pix_n, b_n, a_n});
    oe_pin_n = 1'b0;
    wc(4);
    note("oe_pin_on", 8'h00, {4'h0, sync_n, pix_n, b_n, a_n});
    host_u.wr(ADDR_OE_CTRL, 8'h6f);
    pulse();
    note("latch_on", 8'h00, {7'h0, a_n});
    oe_pin_n = 1'b1;
    wc(10);
    note("latch_hold", 8'h00, {7'h0, a_n});
    pulse();
    note("latch_off", 8'h01, {7'h0, a_n});
    host_u.wr(ADDR_OE_CTRL, 8'h4f);
    oe_pin_n = 1'b0;
    pulse();
    note("delay_1", 8'h01, {7'h0, a_n});
    pulse();
    note("delay_2", 8'h00, {7'h0, a_n});
    $display("enable test done");
    host_u.wr(ADDR_OE_CTRL, 8'h8f);
    for (int c = 0; c < 4; c++) begin
      host_u.wr(ADDR_PWR_LLC, 8'(c));
      wc(2);
      note("lp_oe", {7'h0, c != 0}, {7'h0, a_n});
      k = 0;
      repeat (64) begin
        @(posedge core_clk);
        #1;
        if (stb === 1'b1) k++;
      end
      note("stb_cnt", 8'(64 >> c), 8'(k));
    end
    $display("power test done");
    host_u.wr(ADDR_PWR_LLC, 8'h10);
    note("tdo_bit", 8'h02, {6'h0, tdo, tdo_n});
    host_u.wr(ADDR_PWR_LLC, 8'h00);
    note("tdo_bit", 8'h00, {6'h0, tdo, tdo_n});
    jtag_tlr = 1'b0;
    wc(1);
    note("tdo_jtag", 8'h01, {7'h0, tdo_n});
    jtag_tlr = 1'b1;
    host_u.wr(ADDR_PWR_LLC, 8'h7c);
    note("tdo_off", 8'h01, {7'h0, tdo_n});
    note("slicer", 8'h07, {5'h0, bus_rst, slc, old_t});
    host_u.wr(ADDR_OE_CTRL, 8'h9f);
    for (int j = 0; j < 2; j++) begin
      v = {7'h0, half};
      pulse();
      note("half", {7'h0, ~v[0]}, {7'h0, half});
      note("tdo_clk", {6'h0, ~half, 1'b0}, {6'h0, tdo, tdo_n});
    end
    // Frozen block must ignore a line clock edge
    ce = 1'b0;
    v = {7'h0, half};
    pulse();
    note("ce_hold", v, {7'h0, half});
    ce = 1'b1;
    $display("test output done");
    pb_lines = 8'($urandom);
    wc(5);
    host_u.rd(ADDR_PB_STATE, v);
    note("pb_state", pb_lines, v);
    note("nacks", 8'h00, 8'(host_u.nacks));
    note("sda_out", 8'h00, {7'h0, sda_out});
    $display("status test done");
    give_verdict();
  end
endmodule : oppc_top_test
`default_nettype wire
